// ---- src/tmpk_core.sv ----
// tape word packer with command handling for four 7/9-track transports
// assumes all inputs synchronous to clk; tape side strobes are one-cycle pulses
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tmpk_map.svh"

module tmpk_core
  import tmpk_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [3:0] unit_seven_track,
  input wire logic [3:0] unit_operable,
  input wire logic [3:0] unit_rewinding,
  input wire logic [3:0] unit_write_ring,
  input wire logic [3:0] unit_rewind_done,
  input wire logic gap_window,
  input wire logic tape_char_req,
  input wire logic tape_rx_stb,
  input wire logic [7:0] tape_rx_char,
  input wire logic tape_rx_end,
  output logic [7:0] tape_tx_char,
  output logic tape_tx_stb,
  output logic [1:0] unit_sel,
  output logic write_current,
  output logic fwd_motion,
  output logic busy,
  output logic service_irq
);

  localparam tmpk_state_type TMPK_RST = '0;

  tmpk_state_type s_r;
  tmpk_state_type s_nxt;

  // character for a given position of a word leaving for tape
  function automatic logic [7:0] tx_pick(input logic [15:0] w, input logic [1:0] idx,
                                         input logic nine, input logic ichg,
                                         input logic par_even);
    logic [5:0] c;
    tx_pick = 8'h00;
    c = 6'h00;
    if (nine) begin
      tx_pick = (idx == 2'h0) ? w[15:8] : w[7:0]; // RQ1
    end else begin
      if (ichg) begin
        c = (idx == 2'h0) ? w[13:8] : w[5:0]; // RQ11
      end else begin
        case (idx)
          2'h0: c = w[15:10]; // RQ2
          2'h1: c = w[9:4]; // RQ2
          default: c = {w[3:0], 2'b00}; // RQ2
        endcase
      end
      if (par_even && c == 6'h00) begin
        c = `TMPK_ZERO_SUB; // RQ3
      end
      tx_pick = {2'b00, c};
    end
  endfunction

  // places one tape character into the word being assembled
  function automatic logic [15:0] rx_place(input logic [15:0] w, input logic [7:0] c,
                                           input logic [1:0] idx, input logic nine,
                                           input logic ichg);
    logic [15:0] r;
    r = w;
    if (nine) begin
      if (idx == 2'h0) begin
        r[15:8] = c; // RQ4
      end else begin
        r[7:0] = c; // RQ4
      end
    end else if (ichg) begin
      if (idx == 2'h0) begin
        r[13:8] = c[5:0]; // RQ12
      end else begin
        r[5:0] = c[5:0]; // RQ12
      end
    end else begin
      case (idx)
        2'h0: r[15:10] = c[5:0]; // RQ6
        2'h1: r[9:4] = c[5:0]; // RQ6
        default: r[3:0] = c[5:2]; // RQ6
      endcase
    end
    rx_place = r;
  endfunction

  logic nine_sel;
  logic [1:0] last_idx;
  logic [15:0] cmd;
  logic [2:0] op;
  logic [15:0] status;

  always_comb begin
    nine_sel = ~unit_seven_track[s_r.unit];
    last_idx = (!nine_sel && !s_r.ichg) ? `TMPK_IDX_LAST_BIN : `TMPK_IDX_LAST_PAIR;
    cmd = reg_wdata; // RQ14
    op = cmd[`TMPK_CB_OP];
    status = 16'h0000;
    status[`TMPK_ST_UNIT] = s_r.unit; // RQ18
    status[`TMPK_ST_PARTIAL] = s_r.partial;
    status[`TMPK_ST_WREQ] = (s_r.mode == TMPK_WRITE) && !s_r.wfull;
    status[`TMPK_ST_PATH] = s_r.dmc;
    status[`TMPK_ST_RREADY] = s_r.rfull;
    status[`TMPK_ST_BUSY] = (s_r.mode != TMPK_IDLE);
    status[`TMPK_ST_WRITE_ON] = s_r.write_on;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.tx_stb = 1'b0;
    s_nxt.si = 1'b0;
    s_nxt.rd_data = 16'h0000;

    // deferred unit change lands once the gap window closes
    if (s_r.pend_v && !gap_window) begin
      s_nxt.unit = s_r.pend_unit; // RQ18
      s_nxt.pend_v = 1'b0;
    end

    // outgoing characters, one per tape request
    if (s_r.mode == TMPK_WRITE && tape_char_req && s_r.wfull) begin
      s_nxt.tx_char = tx_pick(s_r.wbuf, s_r.widx, nine_sel, s_r.ichg, s_r.par_even);
      s_nxt.tx_stb = 1'b1;
      if (s_r.widx == last_idx) begin
        s_nxt.widx = 2'h0;
        s_nxt.wfull = 1'b0;
      end else begin
        s_nxt.widx = s_r.widx + 2'h1;
      end
    end

    // reads sit before the tape side so a word landing in the same cycle keeps ready set
    if (reg_rd) begin
      case (reg_addr)
        `TMPK_REG_DATA: begin
          s_nxt.rd_data = s_r.rbuf;
          s_nxt.rfull = 1'b0;
        end
        `TMPK_REG_STATUS: s_nxt.rd_data = status;
        default: s_nxt.rd_data = 16'h0000;
      endcase
    end

    // incoming characters; a full word stays until software reads it or the next full or partial word overwrites it
    if (s_r.mode == TMPK_READ) begin
      if (tape_rx_stb) begin
        if (s_r.ridx == last_idx) begin
          s_nxt.rbuf = rx_place(s_r.asm_word, tape_rx_char, s_r.ridx, nine_sel, s_r.ichg);
          s_nxt.rfull = 1'b1;
          s_nxt.asm_word = 16'h0000;
          s_nxt.ridx = 2'h0;
        end else begin
          s_nxt.asm_word = rx_place(s_r.asm_word, tape_rx_char, s_r.ridx, nine_sel,
                                    s_r.ichg);
          s_nxt.ridx = s_r.ridx + 2'h1;
        end
      end else if (tape_rx_end) begin
        // unfilled bits of the assembly word are still zero from its clear
        if (s_r.ridx != 2'h0) begin
          s_nxt.rbuf = s_r.asm_word; // RQ5 RQ7 RQ8 RQ13
          s_nxt.rfull = 1'b1;
          s_nxt.partial = 1'b1; // RQ5 RQ7 RQ8 RQ13
          s_nxt.asm_word = 16'h0000;
          s_nxt.ridx = 2'h0;
        end
        s_nxt.mode = TMPK_IDLE;
        s_nxt.si = s_r.si_con;
      end
    end

    // scan walks the units one per cycle
    if (s_r.mode == TMPK_SCAN) begin
      if (unit_rewind_done[s_r.scan_idx] && s_r.rew_cmd[s_r.scan_idx]) begin
        s_nxt.mode = TMPK_IDLE; // RQ20
        s_nxt.unit = s_r.scan_idx; // RQ20
        s_nxt.rew_cmd[s_r.scan_idx] = 1'b0;
        s_nxt.si = s_r.si_con; // RQ20
      end else begin
        s_nxt.scan_idx = s_r.scan_idx + 2'h1; // RQ19
      end
    end

    // register writes come last so a new word or command wins over a drain
    if (reg_wr && reg_addr == `TMPK_REG_DATA && s_r.mode == TMPK_WRITE) begin
      s_nxt.wbuf = reg_wdata;
      s_nxt.wfull = 1'b1;
    end
    if (reg_wr && reg_addr == `TMPK_REG_CMD) begin
      s_nxt.si_con = cmd[`TMPK_CB_SICON];
      if (!cmd[`TMPK_CB_SICON]) begin
        s_nxt.rew_cmd = 4'h0; // RQ21
      end
      case (op)
        `TMPK_OP_SELECT: begin
          s_nxt.partial = 1'b0; // RQ17
          s_nxt.rfull = 1'b0; // RQ17
          if (gap_window) begin
            s_nxt.pend_unit = cmd[`TMPK_CB_UNIT]; // RQ18
            s_nxt.pend_v = 1'b1;
          end else begin
            s_nxt.unit = cmd[`TMPK_CB_UNIT]; // RQ16
          end
          if (cmd[`TMPK_CB_SCAN] && s_r.mode == TMPK_IDLE) begin
            s_nxt.mode = TMPK_SCAN; // RQ19
            s_nxt.scan_idx = 2'h0;
          end
        end
        `TMPK_OP_WRITE, `TMPK_OP_READ: begin
          if (s_r.mode == TMPK_IDLE) begin
            s_nxt.partial = 1'b0; // RQ24
            s_nxt.dmc = cmd[`TMPK_CB_PATH]; // RQ15
            s_nxt.ichg = cmd[`TMPK_CB_ICHG] && unit_seven_track[s_r.unit]; // RQ9 RQ10
            s_nxt.par_even = cmd[`TMPK_CB_PARITY] && unit_seven_track[s_r.unit]; // RQ23
            s_nxt.widx = 2'h0;
            s_nxt.wfull = 1'b0;
            s_nxt.ridx = 2'h0;
            s_nxt.asm_word = 16'h0000;
            if (!unit_operable[s_r.unit] || unit_rewinding[s_r.unit]) begin
              s_nxt.si = cmd[`TMPK_CB_SICON];
            end else if (op == `TMPK_OP_READ) begin
              s_nxt.mode = TMPK_READ;
            end else if (unit_write_ring[s_r.unit]) begin
              s_nxt.mode = TMPK_WRITE; // RQ22
              s_nxt.write_on = 1'b1; // RQ22
            end else begin
              s_nxt.si = cmd[`TMPK_CB_SICON];
            end
          end
        end
        `TMPK_OP_TERM: begin
          // a terminate ends any activity; its interrupt masks a racing rewind done
          if (s_r.mode != TMPK_IDLE) begin
            s_nxt.si = cmd[`TMPK_CB_SICON]; // RQ20
          end
          s_nxt.mode = TMPK_IDLE; // RQ19
          s_nxt.write_on = 1'b0;
          s_nxt.wfull = 1'b0;
        end
        `TMPK_OP_REWIND: begin
          if (cmd[`TMPK_CB_SICON]) begin
            s_nxt.rew_cmd[s_r.unit] = 1'b1;
          end
        end
        default: begin
          s_nxt.mode = s_r.mode;
        end
      endcase
    end

    // busy and motion are registered so the pins carry no decode glitches
    s_nxt.busy = (s_nxt.mode != TMPK_IDLE);
    s_nxt.fwd = s_nxt.write_on || (s_nxt.mode == TMPK_READ);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= TMPK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    reg_rdata = s_r.rd_data;
    tape_tx_char = s_r.tx_char;
    tape_tx_stb = s_r.tx_stb;
    unit_sel = s_r.unit;
    write_current = s_r.write_on;
    fwd_motion = s_r.fwd;
    busy = s_r.busy;
    service_irq = s_r.si;
  end

endmodule
`default_nettype wire

// ---- src/tmpk_map.svh ----
// tape word packer: register offsets, command and status fields, encodings
// assumes the includer uses 16-bit words with [15] as the most significant bit
// Functional notes
// RQ1: 9-track write sends upper byte first, lower byte second.
// RQ2: 7-track binary write: bits 15:10, 9:4, then 3:0 with two low tracks zero.
// RQ3: even-parity 7-track write turns an all-zero character into 001010.
// RQ4: 9-track read puts first byte in upper half, second in lower.
// RQ5: odd 9-track block ends with byte in upper half, zeros below, partial set.
// RQ6: 7-track binary read fills three characters, dropping third's two low tracks.
// RQ7: two trailing 7-track characters fill twelve bits, rest zero, partial set.
// RQ8: one trailing 7-track character fills six bits, rest zero, partial set.
// RQ9: packing is binary when command bit 5 is zero; interchange only on 7-track.
// RQ10: a 9-track transport never uses interchange packing.
// RQ11: interchange write sends two six-bit fields, dropping the four others.
// RQ12: interchange read fills two six-bit fields, the four other bits zero.
// RQ13: odd interchange block ends with one character, rest zero, partial set.
// RQ14: host issues a command word; the device takes all sixteen bits.
// RQ15: command bit one picks programmed transfer or direct memory channel.
// RQ16: transport select latches a two-bit unit number.
// RQ17: transport select clears status flags, no busy, no service interrupt.
// RQ18: select during gap window defers; status always shows current unit.
// RQ19: select with scan bit polls rewind complete while busy until ended.
// RQ20: scan ends on first commanded unit done, reports it, interrupts if connected.
// RQ21: disconnecting service interrupts forgets which units were told to rewind.
// RQ22: write starts only on an operable, idle, write-enabled transport.
// RQ23: 9-track forces binary, odd parity; 7-track takes bits from each command.
// RQ24: a new read or write command clears the partial-word flag.
`ifndef TMPK_MAP_SVH
`define TMPK_MAP_SVH

`define TMPK_REG_DATA 2'h0
`define TMPK_REG_STATUS 2'h1
`define TMPK_REG_CMD 2'h2

`define TMPK_CB_UNIT 1:0
`define TMPK_CB_OP 5:3
`define TMPK_CB_PARITY 7
`define TMPK_CB_SCAN 8
`define TMPK_CB_ICHG 10
`define TMPK_CB_SICON 13
`define TMPK_CB_PATH 14

`define TMPK_OP_SELECT 3'h0
`define TMPK_OP_WRITE 3'h1
`define TMPK_OP_READ 3'h2
`define TMPK_OP_TERM 3'h3
`define TMPK_OP_REWIND 3'h4

`define TMPK_ST_UNIT 1:0
`define TMPK_ST_PARTIAL 2
`define TMPK_ST_WREQ 3
`define TMPK_ST_PATH 4
`define TMPK_ST_RREADY 7
`define TMPK_ST_BUSY 8
`define TMPK_ST_WRITE_ON 9

`define TMPK_ZERO_SUB 6'h0A
`define TMPK_IDX_LAST_BIN 2'h2
`define TMPK_IDX_LAST_PAIR 2'h1

`endif

// ---- src/tmpk_pkg.sv ----
// tape word packer types: controller mode and the full state record
// assumes tmpk_map.svh supplies the field positions
package tmpk_pkg;

  typedef enum logic [1:0] {TMPK_IDLE, TMPK_WRITE, TMPK_READ, TMPK_SCAN} tmpk_mode_type;

  typedef struct packed {
    tmpk_mode_type mode;
    logic [1:0] unit;
    logic [1:0] pend_unit;
    logic pend_v;
    logic ichg;
    logic par_even;
    logic si_con;
    logic dmc;
    logic [3:0] rew_cmd;
    logic [1:0] scan_idx;
    logic [15:0] wbuf;
    logic wfull;
    logic [1:0] widx;
    logic [15:0] asm_word;
    logic [1:0] ridx;
    logic [15:0] rbuf;
    logic rfull;
    logic partial;
    logic write_on;
    logic busy;
    logic fwd;
    logic [7:0] tx_char;
    logic tx_stb;
    logic si;
    logic [15:0] rd_data;
  } tmpk_state_type;

endpackage

// ---- sim/tmpk_tape_model.sv ----
// behavioural transport for the tape word packer: write-char requests and read chars
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none

module tmpk_tape_model (
  input wire logic clk,
  input wire logic [7:0] tape_tx_char,
  input wire logic tape_tx_stb,
  output logic tape_char_req,
  output logic tape_rx_stb,
  output logic [7:0] tape_rx_char,
  output logic tape_rx_end
);
  logic [7:0] got[$];

  initial begin
    tape_char_req = 1'b0;
    tape_rx_stb = 1'b0;
    tape_rx_char = 8'h00;
    tape_rx_end = 1'b0;
  end

  always @(posedge clk) begin
    if (tape_tx_stb)
      got.push_back(tape_tx_char);
  end

  // requests spaced apart, as a real transport never asks every cycle
  task automatic pull(input int n);
    repeat (n) begin
      tape_char_req <= 1'b1;
      @(posedge clk);
      tape_char_req <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  // released data line shows the inverse so stale chars are never mistaken
  task automatic feed(input logic [7:0] cs[$], input logic last);
    foreach (cs[i]) begin
      tape_rx_stb <= 1'b1;
      tape_rx_char <= cs[i];
      @(posedge clk);
      tape_rx_stb <= 1'b0;
      tape_rx_char <= ~cs[i];
      @(posedge clk);
    end
    tape_rx_end <= last;
    @(posedge clk);
    tape_rx_end <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- sim/tmpk_core_assertions.sv ----
// port-level checker for the tape word packer command and packing paths
// assumes binding onto tmpk_core; sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "tmpk_map.svh"

module tmpk_core_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [3:0] unit_seven_track,
  input wire logic [3:0] unit_operable,
  input wire logic [3:0] unit_rewinding,
  input wire logic [3:0] unit_write_ring,
  input wire logic gap_window,
  input wire logic tape_char_req,
  input wire logic [7:0] tape_tx_char,
  input wire logic tape_tx_stb,
  input wire logic [1:0] unit_sel,
  input wire logic write_current,
  input wire logic fwd_motion,
  input wire logic busy,
  input wire logic service_irq
);
  logic cmd_w, sel_w, wr_w, wok;
  logic [2:0] op;
  logic [1:0] u;
  assign cmd_w = reg_wr && reg_addr == `TMPK_REG_CMD;
  assign op = reg_wdata[`TMPK_CB_OP];
  assign u = reg_wdata[`TMPK_CB_UNIT];
  assign sel_w = cmd_w && op == `TMPK_OP_SELECT && !busy;
  assign wr_w = cmd_w && op == `TMPK_OP_WRITE && !busy && u == unit_sel;
  assign wok = unit_operable[u] && !unit_rewinding[u] && unit_write_ring[u];

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  tx_after_req_a: assert property (tape_tx_stb |-> $past(tape_char_req))
    else $error("tape char sent without a request");
  seven_top_zero_a: assert property (tape_tx_stb && unit_seven_track[unit_sel]
    |-> tape_tx_char[7:6] == 2'b00) else $error("7-track char has high bits set");
  sel_quiet_a: assert property (sel_w && !reg_wdata[`TMPK_CB_SCAN] |=> !busy && !service_irq)
    else $error("plain select went busy or interrupted");
  sel_unit_a: assert property (sel_w && !gap_window |=> unit_sel == $past(u))
    else $error("select did not latch the unit");
  gap_hold_a: assert property (sel_w && gap_window |=> $stable(unit_sel))
    else $error("unit changed inside gap window");
  scan_busy_a: assert property (sel_w && reg_wdata[`TMPK_CB_SCAN] |=> busy)
    else $error("scan did not go busy");
  wr_start_a: assert property (wr_w && wok |=> write_current && fwd_motion && busy)
    else $error("write did not start motion and current");
  wr_block_a: assert property (wr_w && !wok |=> !write_current)
    else $error("write current on for an unfit transport");
  term_irq_a: assert property (cmd_w && op == `TMPK_OP_TERM && busy
    && reg_wdata[`TMPK_CB_SICON] |-> ##[1:3] service_irq) else $error("no interrupt on terminate");
  term_idle_a: assert property (cmd_w && op == `TMPK_OP_TERM && busy |-> ##[1:3] !busy)
    else $error("terminate left the block busy");

  cover property (sel_w && reg_wdata[`TMPK_CB_SCAN]);
  cover property (service_irq);
  cover property (tape_tx_stb && unit_seven_track[unit_sel]);
endmodule

bind tmpk_core tmpk_core_checker u_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .unit_seven_track, .unit_operable, .unit_rewinding, .unit_write_ring, .gap_window,
  .tape_char_req, .tape_tx_char, .tape_tx_stb, .unit_sel, .write_current, .fwd_motion,
  .busy, .service_irq);
`default_nettype wire

// ---- sim/tmpk_core_tb.sv ----
// self-checking bench for the tape word packer: writes, reads, select, scan
// assumes unit 0 is 9-track, units 1-3 are 7-track and unit 3 is inoperable
`timescale 1ns/1ps
`default_nettype none
`include "tmpk_map.svh"
`define CHK(a, e, s) begin comparisons++; if ((a) !== (e)) begin errors++; $display("[FAIL] %0t %s got %h exp %h", $time, s, a, e); end end

module tmpk_core_tb;
  logic clk, rst_n, reg_wr, reg_rd, gap_window, seen;
  logic tape_char_req, tape_rx_stb, tape_rx_end, tape_tx_stb;
  logic write_current, fwd_motion, busy, service_irq;
  logic [1:0] reg_addr, unit_sel;
  logic [3:0] unit_rewind_done, unit_rewinding, unit_write_ring;
  logic [7:0] tape_tx_char, tape_rx_char, c;
  logic [15:0] reg_wdata, reg_rdata, q;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  localparam logic [15:0] k_ev = 16'h0080, k_sc = 16'h0100, k_ic = 16'h0400;
  localparam logic [15:0] k_si = 16'h2000, k_dm = 16'h4000;

  tmpk_core dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .unit_seven_track(4'hE), .unit_operable(4'h7), .unit_rewinding,
    .unit_write_ring, .unit_rewind_done, .gap_window, .tape_char_req, .tape_rx_stb,
    .tape_rx_char, .tape_rx_end, .tape_tx_char, .tape_tx_stb, .unit_sel, .write_current,
    .fwd_motion, .busy, .service_irq);
  tmpk_tape_model m (.clk, .tape_tx_char, .tape_tx_stb, .tape_char_req, .tape_rx_stb,
    .tape_rx_char, .tape_rx_end);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic go(input logic [2:0] op, input logic [1:0] u, input logic [15:0] f);
    logic [15:0] w;
    w = f;
    w[`TMPK_CB_OP] = op;
    w[`TMPK_CB_UNIT] = u;
    wr(`TMPK_REG_CMD, w);
  endtask

  // read data stand only in the cycle after the strobe, so look there
  task automatic rc(input logic [1:0] a, input logic [15:0] mk, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata & mk;
    `CHK(q, e, "register read")
    @(posedge clk);
  endtask

  task automatic tx(input logic [7:0] e);
    c = m.got.pop_front();
    `CHK(c, e, "tape char")
  endtask

  task automatic waitirq;
    seen = 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1 if (service_irq === 1'b1) seen = 1'b1;
    end
    @(posedge clk);
  endtask

  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 16'h0000;
    gap_window = 1'b0;
    unit_rewind_done = 4'h0;
    unit_rewinding = 4'h0;
    unit_write_ring = 4'hF;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(`TMPK_REG_STATUS, 16'hFFFF, 16'h0000);
    rc(2'h3, 16'hFFFF, 16'h0000);
    go(`TMPK_OP_WRITE, 2'h0, k_ic | k_dm | k_ev);
    rc(`TMPK_REG_STATUS, 16'h0318, 16'h0318);
    wr(`TMPK_REG_DATA, 16'hA5C3);
    m.pull(2);
    tx(8'hA5);
    tx(8'hC3);
    wr(`TMPK_REG_DATA, 16'h0000);
    m.pull(2);
    tx(8'h00);
    tx(8'h00);
    go(`TMPK_OP_TERM, 2'h0, 16'h0000);
    go(`TMPK_OP_SELECT, 2'h1, 16'h0000);
    go(`TMPK_OP_WRITE, 2'h1, k_ev);
    wr(`TMPK_REG_DATA, 16'h03F0);
    m.pull(3);
    tx(8'h0A);
    tx(8'h3F);
    tx(8'h0A);
    go(`TMPK_OP_TERM, 2'h1, 16'h0000);
    go(`TMPK_OP_WRITE, 2'h1, k_ic);
    wr(`TMPK_REG_DATA, 16'hC3FF);
    m.pull(2);
    tx(8'h03);
    tx(8'h3F);
    go(`TMPK_OP_TERM, 2'h1, 16'h0000);
    go(`TMPK_OP_SELECT, 2'h3, 16'h0000);
    go(`TMPK_OP_WRITE, 2'h3, k_si);
    `CHK(write_current, 1'b0, "write on unfit unit")
    unit_write_ring <= 4'hB;
    go(`TMPK_OP_SELECT, 2'h2, 16'h0000);
    go(`TMPK_OP_WRITE, 2'h2, 16'h0000);
    `CHK(busy, 1'b0, "write without ring")
    unit_write_ring <= 4'hF;
    unit_rewinding <= 4'h4;
    go(`TMPK_OP_WRITE, 2'h2, 16'h0000);
    `CHK(busy, 1'b0, "write while rewinding")
    unit_rewinding <= 4'h0;
    $display("test writes done");
    go(`TMPK_OP_SELECT, 2'h0, 16'h0000);
    go(`TMPK_OP_READ, 2'h0, k_ic);
    m.feed('{8'hA5, 8'hC3}, 1'b0);
    rc(`TMPK_REG_DATA, 16'hFFFF, 16'hA5C3);
    m.feed('{8'h7E}, 1'b1);
    rc(`TMPK_REG_DATA, 16'hFFFF, 16'h7E00);
    rc(`TMPK_REG_STATUS, 16'h0104, 16'h0004);
    go(`TMPK_OP_READ, 2'h0, 16'h0000);
    rc(`TMPK_REG_STATUS, 16'h0104, 16'h0100);
    go(`TMPK_OP_TERM, 2'h0, 16'h0000);
    go(`TMPK_OP_SELECT, 2'h1, 16'h0000);
    go(`TMPK_OP_READ, 2'h1, 16'h0000);
    rc(`TMPK_REG_STATUS, 16'h0004, 16'h0000);
    m.feed('{8'h3F, 8'h01, 8'h2D}, 1'b0);
    rc(`TMPK_REG_DATA, 16'hFFFF, 16'hFC1B);
    m.feed('{8'h15, 8'h2A}, 1'b1);
    rc(`TMPK_REG_DATA, 16'hFFFF, 16'h56A0);
    go(`TMPK_OP_READ, 2'h1, 16'h0000);
    m.feed('{8'h3F}, 1'b1);
    rc(`TMPK_REG_DATA, 16'hFFFF, 16'hFC00);
    rc(`TMPK_REG_STATUS, 16'h0004, 16'h0004);
    go(`TMPK_OP_READ, 2'h1, k_ic);
    m.feed('{8'h3F, 8'h15}, 1'b0);
    rc(`TMPK_REG_DATA, 16'hFFFF, 16'h3F15);
    m.feed('{8'h2A}, 1'b1);
    rc(`TMPK_REG_DATA, 16'hFFFF, 16'h2A00);
    rc(`TMPK_REG_STATUS, 16'h0004, 16'h0004);
    $display("test reads done");
    go(`TMPK_OP_SELECT, 2'h2, k_si);
    go(`TMPK_OP_REWIND, 2'h2, k_si);
    go(`TMPK_OP_SELECT, 2'h0, k_sc | k_si);
    `CHK(busy, 1'b1, "scan busy")
    unit_rewind_done <= 4'h4;
    waitirq();
    `CHK(seen, 1'b1, "scan end interrupt")
    rc(`TMPK_REG_STATUS, 16'h0103, 16'h0002);
    go(`TMPK_OP_SELECT, 2'h3, k_si);
    go(`TMPK_OP_REWIND, 2'h3, k_si);
    go(`TMPK_OP_SELECT, 2'h0, 16'h0000);
    unit_rewind_done <= 4'h8;
    go(`TMPK_OP_SELECT, 2'h0, k_sc | k_si);
    repeat (10) @(posedge clk);
    `CHK(busy, 1'b1, "scan after forget")
    go(`TMPK_OP_TERM, 2'h0, k_si);
    `CHK(busy, 1'b0, "terminate scan")
    gap_window <= 1'b1;
    go(`TMPK_OP_SELECT, 2'h1, 16'h0000);
    `CHK(unit_sel, 2'h0, "unit held in gap")
    gap_window <= 1'b0;
    repeat (3) @(posedge clk);
    rc(`TMPK_REG_STATUS, 16'h0003, 16'h0001);
    $display("test select and scan done");
    conclude();
  end
endmodule
`default_nettype wire
